// ==== core/ldci_pkg.sv ====
/*
 * Shared constants and types of the command link: widths, burst length
 * coding, address masks and timing counts.
 * Assumes a 200 MHz local clock at both ends.
 */
package ldci_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W = 22;
    localparam int BANK_W = 3;
    localparam int DATA_W = 18;
    localparam int MODE_W = 18;

    // ----------------------------------------
    // Mode word fields and masks
    // ----------------------------------------
    localparam int BL_LSB = 3;
    localparam logic [1:0] BL_CODE_4 = 2'h1;
    localparam logic [1:0] BL_CODE_8 = 2'h2;
    localparam logic [MODE_W-1:0] MODE_RST = 18'h00000;
    localparam logic [ADDR_W-1:0] AMASK_BL2 = 22'h1FFFFF;
    localparam logic [ADDR_W-1:0] AMASK_BL4 = 22'h0FFFFF;
    localparam logic [ADDR_W-1:0] AMASK_BL8 = 22'h07FFFF;
    localparam logic [ADDR_W-1:0] MODE_KEEP = 22'h0003FF;
    localparam logic [3:0] BEATS_2 = 4'h2;
    localparam logic [3:0] BEATS_4 = 4'h4;
    localparam logic [3:0] BEATS_8 = 4'h8;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS = 5;
    localparam int CK_RESET_NS = 30;
    localparam int LOCK_US = 15;
    localparam int MRSC_CYC = 6;
    localparam logic [2:0] STATIC_CNT = 3'((CK_RESET_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] LOCK_CNT = 12'((LOCK_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] MRSC_CNT = 3'(MRSC_CYC - 1);

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_RFSH = 2'h2,
        OP_MODE = 2'h3
    } ldci_op_t;

    // Beats per burst for a burst length code
    function automatic logic [3:0] bl_beats(input logic [1:0] code);
        bl_beats = (code == BL_CODE_4) ? BEATS_4 : (code == BL_CODE_8) ? BEATS_8 : BEATS_2;
    endfunction

    // Usable address bits for a burst length code
    function automatic logic [ADDR_W-1:0] addr_mask(input logic [1:0] code);
        addr_mask = (code == BL_CODE_4) ? AMASK_BL4 : (code == BL_CODE_8) ? AMASK_BL8 : AMASK_BL2;
    endfunction

endpackage

// ==== core/ldci_link_if.sv ====
/*
 * Pins between the controller end and the device end.
 * Assumes the controller drives every signal; the device only samples.
 */
interface ldci_link_if;
    import ldci_pkg::*;

    logic cmd_clk;
    logic chip_sel_n;
    logic wr_en_n;
    logic rfsh_n;
    logic [ADDR_W-1:0] addr;
    logic [BANK_W-1:0] bank_sel;
    logic [DATA_W-1:0] wdata;
    logic byte_mask_in;

    modport ctrl (
        output cmd_clk, chip_sel_n, wr_en_n, rfsh_n, addr, bank_sel, wdata, byte_mask_in
    );
    modport dev (
        input cmd_clk, chip_sel_n, wr_en_n, rfsh_n, addr, bank_sel, wdata, byte_mask_in
    );

endinterface

// ==== core/ldci_dev.sv ====
/*
 * Device end: decodes commands on the link clock, tracks the mode word
 * and write bursts, and watches the link clock for stops and relock.
 * Assumes the controller keeps the link clock running while reset_n is
 * low, and clk is a free 200 MHz local clock.
 */
module ldci_dev
    import ldci_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    ldci_link_if.dev link,
    output logic cmd_valid_q,
    output ldci_op_t cmd_op_q,
    output logic [BANK_W-1:0] cmd_bank_q,
    output logic [ADDR_W-1:0] cmd_addr_q,
    output logic beat_valid_q,
    output logic [BANK_W-1:0] beat_bank_q,
    output logic [ADDR_W-1:0] beat_addr_q,
    output logic [2:0] beat_idx_q,
    output logic [DATA_W-1:0] beat_data_q,
    output logic [MODE_W-1:0] mode_reg_q,
    output logic [3:0] burst_len_q,
    output logic rd_unlocked_q,
    output logic pll_locked_q
);

    // ----------------------------------------
    // Link domain: reset and lock crossing
    // ----------------------------------------
    logic rst_s1_q;
    logic lrst_n_q;
    logic lk_s1_q;
    logic lk_s2_q;

    // Two-stage level crossings into the link clock
    always_ff @(posedge link.cmd_clk) begin
        rst_s1_q <= reset_n;
        lrst_n_q <= rst_s1_q;
        lk_s1_q <= pll_locked_q;
        lk_s2_q <= lk_s1_q;
    end

    // ----------------------------------------
    // Link domain: command decode
    // ----------------------------------------
    logic sel;
    logic is_rd;
    logic is_wr;
    logic is_rf;
    logic is_md;
    logic [ADDR_W-1:0] amask;
    logic cmd_valid_d;
    ldci_op_t cmd_op_d;
    logic [BANK_W-1:0] cmd_bank_d;
    logic [ADDR_W-1:0] cmd_addr_d;
    logic [MODE_W-1:0] mode_reg_d;
    logic [3:0] burst_len_d;
    logic rd_unlocked_d;

    // Strobe decode and command record
    always_comb begin
        sel = !link.chip_sel_n;
        is_rd = sel && link.wr_en_n && link.rfsh_n;
        is_wr = sel && !link.wr_en_n && link.rfsh_n;
        is_rf = sel && link.wr_en_n && !link.rfsh_n;
        is_md = sel && !link.wr_en_n && !link.rfsh_n;
        amask = addr_mask(mode_reg_q[BL_LSB +: 2]);
        cmd_valid_d = sel;
        cmd_op_d = cmd_op_q;
        cmd_bank_d = cmd_bank_q;
        cmd_addr_d = cmd_addr_q;
        mode_reg_d = mode_reg_q;
        burst_len_d = burst_len_q;
        rd_unlocked_d = is_rd && !lk_s2_q;
        if (is_rd || is_wr) begin
            cmd_op_d = is_rd ? OP_READ : OP_WRITE;
            cmd_bank_d = link.bank_sel;
            cmd_addr_d = link.addr & amask;
        end
        if (is_rf) begin
            cmd_op_d = OP_RFSH;
            cmd_bank_d = link.bank_sel;
            cmd_addr_d = '0;
        end
        if (is_md) begin
            cmd_op_d = OP_MODE;
            cmd_bank_d = '0;
            cmd_addr_d = {4'h0, link.addr[MODE_W-1:0]};
            mode_reg_d = link.addr[MODE_W-1:0];
            burst_len_d = bl_beats(link.addr[BL_LSB +: 2]);
        end
    end

    // Command record registers
    always_ff @(posedge link.cmd_clk) begin
        if (!lrst_n_q) begin
            cmd_valid_q <= 1'b0;
            cmd_op_q <= OP_READ;
            cmd_bank_q <= '0;
            cmd_addr_q <= '0;
            mode_reg_q <= MODE_RST;
            burst_len_q <= BEATS_2;
            rd_unlocked_q <= 1'b0;
        end else begin
            cmd_valid_q <= cmd_valid_d;
            cmd_op_q <= cmd_op_d;
            cmd_bank_q <= cmd_bank_d;
            cmd_addr_q <= cmd_addr_d;
            mode_reg_q <= mode_reg_d;
            burst_len_q <= burst_len_d;
            rd_unlocked_q <= rd_unlocked_d;
        end
    end

    // ----------------------------------------
    // Link domain: write burst
    // ----------------------------------------
    logic [3:0] wr_rem_q;
    logic [3:0] wr_rem_d;
    logic [2:0] wr_idx_q;
    logic [2:0] wr_idx_d;
    logic [BANK_W-1:0] wr_bank_q;
    logic [BANK_W-1:0] wr_bank_d;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [ADDR_W-1:0] wr_addr_d;
    logic beat_valid_d;
    logic [BANK_W-1:0] beat_bank_d;
    logic [ADDR_W-1:0] beat_addr_d;
    logic [2:0] beat_idx_d;
    logic [DATA_W-1:0] beat_data_d;

    // Beats run on regardless of chip select; a new write restarts
    always_comb begin
        wr_rem_d = wr_rem_q;
        wr_idx_d = wr_idx_q;
        wr_bank_d = wr_bank_q;
        wr_addr_d = wr_addr_q;
        beat_valid_d = 1'b0;
        beat_bank_d = beat_bank_q;
        beat_addr_d = beat_addr_q;
        beat_idx_d = beat_idx_q;
        beat_data_d = beat_data_q;
        if (wr_rem_q != 4'h0) begin
            beat_valid_d = !link.byte_mask_in;
            beat_bank_d = wr_bank_q;
            beat_addr_d = wr_addr_q;
            beat_idx_d = wr_idx_q;
            beat_data_d = link.wdata;
            wr_rem_d = wr_rem_q - 4'h1;
            wr_idx_d = wr_idx_q + 3'h1;
        end
        if (is_wr) begin
            wr_rem_d = burst_len_q;
            wr_idx_d = 3'h0;
            wr_bank_d = link.bank_sel;
            wr_addr_d = link.addr & amask;
        end
    end

    // Write burst registers
    always_ff @(posedge link.cmd_clk) begin
        if (!lrst_n_q) begin
            wr_rem_q <= 4'h0;
            wr_idx_q <= 3'h0;
            wr_bank_q <= '0;
            wr_addr_q <= '0;
            beat_valid_q <= 1'b0;
            beat_bank_q <= '0;
            beat_addr_q <= '0;
            beat_idx_q <= 3'h0;
            beat_data_q <= '0;
        end else begin
            wr_rem_q <= wr_rem_d;
            wr_idx_q <= wr_idx_d;
            wr_bank_q <= wr_bank_d;
            wr_addr_q <= wr_addr_d;
            beat_valid_q <= beat_valid_d;
            beat_bank_q <= beat_bank_d;
            beat_addr_q <= beat_addr_d;
            beat_idx_q <= beat_idx_d;
            beat_data_q <= beat_data_d;
        end
    end

    // ----------------------------------------
    // Local domain: link clock watch and PLL lock
    // ----------------------------------------
    logic ck_s1_q;
    logic ck_s2_q;
    logic ck_s3_q;
    logic ck_f_q;
    logic ck_f_d;
    logic [2:0] stat_q;
    logic [2:0] stat_d;
    logic [11:0] lock_q;
    logic [11:0] lock_d;
    logic pll_locked_d;

    // Three-stage sampler of the link clock
    always_ff @(posedge clk) begin
        ck_s1_q <= link.cmd_clk;
        ck_s2_q <= ck_s1_q;
        ck_s3_q <= ck_s2_q;
    end

    // A stop of the link clock drops lock; toggling rebuilds it
    always_comb begin
        ck_f_d = ck_f_q;
        stat_d = stat_q;
        lock_d = lock_q;
        pll_locked_d = pll_locked_q;
        if (ck_s2_q == ck_s3_q && ck_s3_q != ck_f_q) begin
            ck_f_d = ck_s3_q;
            stat_d = 3'h0;
        end else if (stat_q != STATIC_CNT) begin
            stat_d = stat_q + 3'h1;
        end
        if (stat_d == STATIC_CNT) begin
            lock_d = 12'h000;
            pll_locked_d = 1'b0;
        end else if (lock_q != LOCK_CNT) begin
            lock_d = lock_q + 12'h001;
        end else begin
            pll_locked_d = 1'b1;
        end
    end

    // Lock monitor registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ck_f_q <= 1'b0;
            stat_q <= 3'h0;
            lock_q <= 12'h000;
            pll_locked_q <= 1'b0;
        end else begin
            ck_f_q <= ck_f_d;
            stat_q <= stat_d;
            lock_q <= lock_d;
            pll_locked_q <= pll_locked_d;
        end
    end

endmodule

// ==== core/ldci_ctrl.sv ====
/*
 * Controller end: divides clk by four into the link clock, issues one
 * command per link cycle, feeds write beats from a two-entry buffer and
 * honours the mode-load wait, and holds reads (not writes, refreshes or mode loads) for the relock time.
 * Assumes the user holds a request stable while req_valid is high.
 */
module ldci_ctrl
    import ldci_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    ldci_link_if.ctrl link,
    input wire logic req_valid,
    input wire ldci_op_t req_op,
    input wire logic [BANK_W-1:0] req_bank,
    input wire logic [ADDR_W-1:0] req_addr,
    output logic req_ready_q,
    input wire logic wd_valid,
    input wire logic [DATA_W-1:0] wd_data,
    output logic wd_ready_q,
    input wire logic clk_stop_req,
    output logic clk_stopped_q,
    output logic relock_q
);

    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_STOP = 3'h2,
        ST_RELOCK = 3'h4
    } ldci_state_t;

    // ----------------------------------------
    // Link clock divider (free running, so reset reaches the device)
    // ----------------------------------------
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic cmd_clk_q;
    ldci_state_t st_q;
    ldci_state_t st_d;

    // Divide by four; held low while stopped
    always_comb begin
        cnt_d = 2'h0;
        if (cnt_q == 2'h0) begin
            cnt_d = 2'h1;
        end else if (cnt_q == 2'h1) begin
            cnt_d = 2'h2;
        end else if (cnt_q == 2'h2) begin
            cnt_d = 2'h3;
        end
    end

    // Divider registers
    always_ff @(posedge clk) begin
        cnt_q <= cnt_d;
        cmd_clk_q <= (st_q == ST_STOP) ? 1'b0 : cnt_d[1];
    end

    // ----------------------------------------
    // Write data buffer
    // ----------------------------------------
    logic [DATA_W-1:0] buf_q [2];
    logic [DATA_W-1:0] buf_d [2];
    logic wp_q;
    logic wp_d;
    logic rp_q;
    logic rp_d;
    logic [1:0] fill_q;
    logic [1:0] fill_d;
    logic push;
    logic pop;
    logic wd_ready_d;
    logic [3:0] rem_q;
    logic [3:0] rem_d;
    logic tick;

    // Fill from the user, drain one word per write beat
    always_comb begin
        tick = cnt_q == 2'h3;
        push = wd_valid && wd_ready_q;
        pop = tick && rem_q != 4'h0 && fill_q != 2'h0;
        buf_d = buf_q;
        wp_d = wp_q ^ push;
        rp_d = rp_q ^ pop;
        if (push) begin
            buf_d[wp_q] = wd_data;
        end
        fill_d = 2'(fill_q + {1'b0, push} - {1'b0, pop});
        wd_ready_d = fill_d != 2'h2;
    end

    // Buffer registers
    always_ff @(posedge clk) begin
        buf_q <= buf_d;
        if (!reset_n) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            fill_q <= 2'h0;
            wd_ready_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            fill_q <= fill_d;
            wd_ready_q <= wd_ready_d;
        end
    end

    // ----------------------------------------
    // Command issue and sequencing
    // ----------------------------------------
    logic ok;
    logic take;
    logic req_ready_d;
    logic [2:0] mrs_q;
    logic [2:0] mrs_d;
    logic [1:0] bl_q;
    logic [1:0] bl_d;
    logic [11:0] lock_q;
    logic [11:0] lock_d;
    logic cs_n_q;
    logic cs_n_d;
    logic we_n_q;
    logic we_n_d;
    logic rf_n_q;
    logic rf_n_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [BANK_W-1:0] bank_q;
    logic [BANK_W-1:0] bank_d;
    logic [DATA_W-1:0] wdat_q;
    logic [DATA_W-1:0] wdat_d;
    logic mask_q;
    logic mask_d;

    // Ready is offered in the cycle before each command slot
    always_comb begin
        ok = mrs_q == 3'h0 && !clk_stop_req && st_q != ST_STOP;
        if (req_op == OP_READ) begin
            ok = ok && st_q == ST_RUN;
        end else if (req_op != OP_RFSH) begin
            ok = ok && rem_q == 4'h0;
        end
        req_ready_d = cnt_q == 2'h2 && ok;
        take = tick && req_valid && req_ready_q;
        st_d = st_q;
        lock_d = lock_q;
        mrs_d = mrs_q;
        bl_d = bl_q;
        rem_d = rem_q;
        cs_n_d = cs_n_q;
        we_n_d = we_n_q;
        rf_n_d = rf_n_q;
        addr_d = addr_q;
        bank_d = bank_q;
        wdat_d = wdat_q;
        mask_d = mask_q;
        unique case (st_q)
            ST_RUN: begin
                if (tick && clk_stop_req && rem_q == 4'h0 && mrs_q == 3'h0) begin
                    st_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (tick && !clk_stop_req) begin
                    st_d = ST_RELOCK;
                    lock_d = 12'h000;
                end
            end
            ST_RELOCK: begin
                if (lock_q == LOCK_CNT - 12'h001) begin
                    st_d = ST_RUN;
                end else begin
                    lock_d = lock_q + 12'h001;
                end
            end
            default: begin
                st_d = ST_RELOCK;
                lock_d = 12'h000;
            end
        endcase
        if (tick) begin
            cs_n_d = 1'b1;
            we_n_d = 1'b1;
            rf_n_d = 1'b1;
            mask_d = 1'b1;
            if (mrs_q != 3'h0) begin
                mrs_d = mrs_q - 3'h1;
            end
            if (rem_q != 4'h0) begin
                rem_d = rem_q - 4'h1;
                mask_d = fill_q == 2'h0;
                wdat_d = buf_q[rp_q];
            end
            if (take) begin
                cs_n_d = 1'b0;
                we_n_d = !(req_op == OP_WRITE || req_op == OP_MODE);
                rf_n_d = !(req_op == OP_RFSH || req_op == OP_MODE);
                bank_d = (req_op == OP_MODE) ? '0 : req_bank;
                addr_d = req_addr & addr_mask(bl_q);
                if (req_op == OP_RFSH) begin
                    addr_d = '0;
                end
                if (req_op == OP_WRITE) begin
                    rem_d = bl_beats(bl_q);
                end
                if (req_op == OP_MODE) begin
                    addr_d = req_addr & MODE_KEEP;
                    bl_d = req_addr[BL_LSB +: 2];
                    mrs_d = MRSC_CNT;
                end
            end
        end
    end

    // Sequencer and pin registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_q <= ST_RELOCK;
            lock_q <= 12'h000;
            mrs_q <= 3'h0;
            bl_q <= 2'h0;
            rem_q <= 4'h0;
            req_ready_q <= 1'b0;
            cs_n_q <= 1'b1;
            we_n_q <= 1'b1;
            rf_n_q <= 1'b1;
            addr_q <= '0;
            bank_q <= '0;
            wdat_q <= '0;
            mask_q <= 1'b1;
            clk_stopped_q <= 1'b0;
            relock_q <= 1'b1;
        end else begin
            st_q <= st_d;
            lock_q <= lock_d;
            mrs_q <= mrs_d;
            bl_q <= bl_d;
            rem_q <= rem_d;
            req_ready_q <= req_ready_d;
            cs_n_q <= cs_n_d;
            we_n_q <= we_n_d;
            rf_n_q <= rf_n_d;
            addr_q <= addr_d;
            bank_q <= bank_d;
            wdat_q <= wdat_d;
            mask_q <= mask_d;
            clk_stopped_q <= st_d == ST_STOP;
            relock_q <= st_d == ST_RELOCK;
        end
    end

    // Pins change on the falling link clock edge, stable at the rise
    assign link.cmd_clk = cmd_clk_q;
    assign link.chip_sel_n = cs_n_q;
    assign link.wr_en_n = we_n_q;
    assign link.rfsh_n = rf_n_q;
    assign link.addr = addr_q;
    assign link.bank_sel = bank_q;
    assign link.wdata = wdat_q;
    assign link.byte_mask_in = mask_q;

endmodule

// ==== test/ldci_assertions.sv ====
/*
 * Checks on the link pins between the two ends.
 * Assumes both ends share reset_n; inputs come straight off the interface.
 */
module ldci_assertions
    import ldci_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_clk,
    input wire logic chip_sel_n,
    input wire logic wr_en_n,
    input wire logic rfsh_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [BANK_W-1:0] bank_sel,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic byte_mask_in
);
    // ----
    // Helper logic
    // ----
    localparam int LOCK_MIN = 2990;
    logic is_mode, is_wr, is_rfsh, is_rd, ck_q, ck_d, rst_seen_q;
    logic [3:0] bl_q, bl_d, since_q, since_d;
    logic [2:0] st_q, st_d;
    logic [11:0] run_q, run_d;

    // Command decode of the pins
    assign is_mode = !chip_sel_n && !wr_en_n && !rfsh_n;
    assign is_wr = !chip_sel_n && !wr_en_n && rfsh_n;
    assign is_rfsh = !chip_sel_n && wr_en_n && !rfsh_n;
    assign is_rd = !chip_sel_n && wr_en_n && rfsh_n;

    // Burst length and link cycles since the last write
    always_comb begin
        bl_d = bl_q;
        since_d = (since_q == 4'hF) ? since_q : since_q + 4'h1;
        if (is_mode) begin
            bl_d = (addr[4:3] == BL_CODE_4) ? BEATS_4 : (addr[4:3] == BL_CODE_8) ? BEATS_8 : BEATS_2;
        end
        if (is_wr) begin
            since_d = 4'h0;
        end
    end
    always_ff @(posedge cmd_clk) begin
        bl_q <= reset_n ? bl_d : BEATS_2;
        since_q <= reset_n ? since_d : 4'hF;
    end

    // Static time of the link clock and toggling time since it last stood
    always_comb begin
        ck_d = cmd_clk;
        st_d = (cmd_clk != ck_q) ? 3'h0 : (st_q == STATIC_CNT) ? st_q : st_q + 3'h1;
        run_d = (st_q == STATIC_CNT) ? 12'h000 : (run_q == 12'hFFF) ? run_q : run_q + 12'h001;
    end
    always_ff @(posedge clk) begin
        ck_q <= ck_d;
        rst_seen_q <= !reset_n;
        st_q <= reset_n ? st_d : 3'h0;
        run_q <= reset_n ? run_d : 12'h000;
    end

    // ----
    // Assertions
    // ----
    chk_mode_wait_gap: assert property (@(posedge cmd_clk) disable iff (!reset_n) is_mode |=> chip_sel_n [*5])
        else $error("command too soon after mode load");
    chk_mode_high_zero: assert property (@(posedge cmd_clk) disable iff (!reset_n)
        is_mode |-> addr[17:10] == 8'h00 && bank_sel == 3'h0)
        else $error("mode load with upper opcode bits set");
    chk_rfsh_addr_zero: assert property (@(posedge cmd_clk) disable iff (!reset_n) is_rfsh |-> addr == 22'h000000)
        else $error("refresh with nonzero address");
    chk_write_no_mode: assert property (@(posedge cmd_clk) disable iff (!reset_n) is_wr |=> !is_mode [*2])
        else $error("mode load during write burst");
    chk_mask_in_burst: assert property (@(posedge cmd_clk) disable iff (!reset_n)
        !byte_mask_in && chip_sel_n |-> since_q < bl_q)
        else $error("unmasked beat outside a write burst");
    chk_read_lock_wait: assert property (@(posedge clk) disable iff (!reset_n) is_rd |-> run_q >= LOCK_MIN)
        else $error("read before link clock toggled long enough");
    chk_pins_hold_edge: assert property (@(posedge clk) disable iff (!reset_n) $rose(cmd_clk) |->
        $stable({chip_sel_n, wr_en_n, rfsh_n, bank_sel, addr}) ##1 $stable({chip_sel_n, wr_en_n, rfsh_n, bank_sel, addr}))
        else $error("command pins moved at link clock rise");
    chk_reset_deselect: assert property (@(posedge clk) !reset_n && rst_seen_q |-> chip_sel_n && byte_mask_in)
        else $error("pins not idle in reset");

    // Main scenarios seen
    cov_mode: cover property (@(posedge cmd_clk) disable iff (!reset_n) is_mode);
    cov_write: cover property (@(posedge cmd_clk) disable iff (!reset_n) is_wr ##1 !byte_mask_in);
    cov_rfsh: cover property (@(posedge cmd_clk) disable iff (!reset_n) is_rfsh);
    cov_stop: cover property (@(posedge clk) disable iff (!reset_n) st_q == STATIC_CNT);
endmodule

// ==== test/ldram_command_interface_tb.sv ====
/*
 * Bench: controller and device ends joined by the link interface.
 * Assumes the core/ files are compiled first.
 */
module ldram_command_interface_tb
    import ldci_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ----
    // Signals and instances
    // ----
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    ldci_op_t req_op = OP_READ;
    logic [BANK_W-1:0] req_bank = 3'h0;
    logic [ADDR_W-1:0] req_addr = 22'h000000;
    logic wd_valid = 1'b0;
    logic [DATA_W-1:0] wd_data = 18'h00000;
    logic clk_stop_req = 1'b0;
    logic req_ready_q, wd_ready_q, clk_stopped_q, relock_q, cmd_valid_q, beat_valid_q, rd_unlocked_q, pll_locked_q;
    ldci_op_t cmd_op_q;
    logic [BANK_W-1:0] cmd_bank_q, beat_bank_q;
    logic [ADDR_W-1:0] cmd_addr_q, beat_addr_q;
    logic [2:0] beat_idx_q;
    logic [DATA_W-1:0] beat_data_q;
    logic [MODE_W-1:0] mode_reg_q;
    logic [3:0] burst_len_q;
    int n_fail = 0;
    int comparisons = 0;
    int n_cmd = 0;
    logic unl = 1'b0;
    logic [31:0] g_cmd = 32'h00000000;
    logic [20:0] beats[$];

    ldci_link_if ldci_link_if_i ();
    ldci_ctrl ldci_ctrl_i (.clk, .reset_n, .link(ldci_link_if_i), .req_valid, .req_op, .req_bank, .req_addr,
        .req_ready_q, .wd_valid, .wd_data, .wd_ready_q, .clk_stop_req, .clk_stopped_q, .relock_q);
    ldci_dev ldci_dev_i (.clk, .reset_n, .link(ldci_link_if_i), .cmd_valid_q, .cmd_op_q, .cmd_bank_q, .cmd_addr_q,
        .beat_valid_q, .beat_bank_q, .beat_addr_q, .beat_idx_q, .beat_data_q, .mode_reg_q, .burst_len_q,
        .rd_unlocked_q, .pll_locked_q);
    ldci_assertions ldci_assertions_i (.clk, .reset_n, .cmd_clk(ldci_link_if_i.cmd_clk),
        .chip_sel_n(ldci_link_if_i.chip_sel_n), .wr_en_n(ldci_link_if_i.wr_en_n), .rfsh_n(ldci_link_if_i.rfsh_n),
        .addr(ldci_link_if_i.addr), .bank_sel(ldci_link_if_i.bank_sel), .wdata(ldci_link_if_i.wdata),
        .byte_mask_in(ldci_link_if_i.byte_mask_in));

    // Local clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Record what the device end reports at each link clock rise
    always @(posedge ldci_link_if_i.cmd_clk) begin
        if (cmd_valid_q === 1'b1) begin
            n_cmd++;
            g_cmd = {5'h00, cmd_op_q, cmd_bank_q, cmd_addr_q};
        end
        if (beat_valid_q === 1'b1) begin
            beats.push_back({beat_idx_q, beat_data_q});
        end
        if (rd_unlocked_q === 1'b1) begin
            unl = 1'b1;
        end
    end

    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One request through the controller, then wait until the device reports it
    task automatic issue(input ldci_op_t op, input logic [2:0] bank, input logic [21:0] addr);
        int n0;
        int i;
        n0 = n_cmd;
        i = 0;
        @(posedge clk);
        req_op <= op;
        req_bank <= bank;
        req_addr <= addr;
        req_valid <= 1'b1;
        do begin
            @(posedge clk);
            i++;
        end while (req_ready_q !== 1'b1 && i < 200);
        req_valid <= 1'b0;
        i = 0;
        while (n_cmd == n0 && i < 40) begin
            @(posedge clk);
            i++;
        end
        if (n_cmd == n0) begin
            n_fail++;
        end
    endtask

    // One word into the write buffer, which must have room
    task automatic push(input logic [17:0] d);
        @(posedge clk);
        wd_data <= d;
        wd_valid <= 1'b1;
        @(posedge clk);
        wd_valid <= 1'b0;
    endtask

    // Wait out the controller's relock time
    task automatic wait_free();
        int i;
        i = 0;
        while (relock_q !== 1'b0 && i < 4000) begin
            @(posedge clk);
            i++;
        end
        if (relock_q !== 1'b0) begin
            n_fail++;
        end
        repeat (20) @(posedge clk);
    endtask

    task automatic close_out();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----
    // Tests
    // ----
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        // Let the link-side reset sync settle before the first command
        repeat (16) @(posedge clk);
        issue(OP_MODE, 3'h7, 22'h3FFC08);
        chk(g_cmd, {5'h00, OP_MODE, 3'h0, 22'h000008});
        chk(mode_reg_q, 18'h00008);
        chk(burst_len_q, BEATS_4);
        $display("test mode_load done");
        issue(OP_RFSH, 3'h3, 22'h155555);
        chk(g_cmd, {5'h00, OP_RFSH, 3'h3, 22'h000000});
        $display("test refresh done");
        // Only two words buffered: the last two beats go out masked
        push(18'h2AAAA);
        push(18'h15555);
        repeat (2) @(posedge clk);
        chk(wd_ready_q, 1'b0);
        beats.delete();
        issue(OP_WRITE, 3'h6, 22'h3FFFFF);
        chk(g_cmd, {5'h00, OP_WRITE, 3'h6, AMASK_BL4});
        repeat (40) @(posedge clk);
        chk(beats.size(), 2);
        chk(beats[0], {3'h0, 18'h2AAAA});
        chk(beats[1], {3'h1, 18'h15555});
        chk({7'h00, beat_bank_q, beat_addr_q}, {7'h00, 3'h6, AMASK_BL4});
        $display("test write done");
        wait_free();
        chk(pll_locked_q, 1'b1);
        issue(OP_READ, 3'h5, 22'h2ABCDE);
        chk(g_cmd, {5'h00, OP_READ, 3'h5, 22'h0ABCDE});
        $display("test read done");
        // Stop the link clock, then count out the relock
        clk_stop_req <= 1'b1;
        repeat (40) @(posedge clk);
        chk(clk_stopped_q, 1'b1);
        chk(pll_locked_q, 1'b0);
        clk_stop_req <= 1'b0;
        repeat (2900) @(posedge clk);
        chk(pll_locked_q, 1'b0);
        chk(relock_q, 1'b1);
        wait_free();
        chk(pll_locked_q, 1'b1);
        issue(OP_MODE, 3'h0, 22'h000010);
        chk(burst_len_q, BEATS_8);
        issue(OP_READ, 3'h2, 22'h3FFFFF);
        chk(g_cmd, {5'h00, OP_READ, 3'h2, AMASK_BL8});
        chk(unl, 1'b0);
        $display("test clock_stop done");
        close_out();
    end

    // Cut a hung run short
    initial begin
        repeat (12000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule
